// ==== acc_pkg.sv ====
// Constants and types shared by the analog converter control block.
// Behaviour
// (R1) Reset clears data low, high, control.
// (R2) Low holds bits 7..0, high bits 9..8.
// (R3) Data writes always update the holding register.
// (R4) Data reads: result in input mode, else holding.
// (R5) Channel select 00..11 picks channel one..four.
// (R6) Direction 0 input mode, 1 output mode.
// (R7) Input mode with channel four: differential pair.
// (R8) Interrupt needs flag, block and global enables.
// (R9) Finished input conversion sets the done flag.
// (R10) Software only clears flag; writing one keeps it.
// (R11) Start condition: control write, enable, flag clear.
// (R12) Start pulse on next edge begins conversion.
// (R13) No conversion begins without the enable bit.
// (R14) Control layout: flag7, irq4, en3, dir2, sel1:0.
// (R15) Software clears flag for every conversion.
// (R16) Software must not restart a running conversion.
// (R17) Result loads first, flag sets afterwards.
// (R18) Input conversion 240 us, output under 10 us.
// (R19) Result code spans 0 to 1023 linearly.
// (R20) Software discards first differential result.
// (R21) Polling: start, test flag, read low, high.
// (R22) Output start transfers holding word to generator.
// (R23) Duration is a cycle count with busy state.
// (R24) Control bits 6 and 5 read zero.
package acc_pkg;

    // Register addresses in the core data space.
    localparam logic [7:0] ACC_ADDR_DATA_LOW = 8'h9d;
    localparam logic [7:0] ACC_ADDR_DATA_HIGH = 8'h9e;
    localparam logic [7:0] ACC_ADDR_CONTROL = 8'h9f;

    // Reset values of the three registers.
    localparam logic [7:0] ACC_RST_DATA_LOW = 8'h00;
    localparam logic [7:0] ACC_RST_DATA_HIGH = 8'h00;
    localparam logic [7:0] ACC_RST_CONTROL = 8'h00;
    localparam logic [7:0] ACC_READ_ZERO = 8'h00;

    // Converter word layout.
    localparam int ACC_WORD_W = 10;
    localparam int ACC_LOW_W = 8;
    localparam int ACC_HIGH_W = 2;

    // Control register field positions.
    localparam int ACC_BIT_DONE = 7;
    localparam int ACC_BIT_IRQ_EN = 4;
    localparam int ACC_BIT_ENABLE = 3;
    localparam int ACC_BIT_DIR = 2;
    localparam int ACC_BIT_SEL_HI = 1;
    localparam int ACC_BIT_SEL_LO = 0;

    // Channel select code of the fourth channel.
    localparam logic [1:0] ACC_SEL_CH_FOUR = 2'h3;

    // Timing figures and their cycle counts at the core clock rate.
    localparam int ACC_CLK_PERIOD_PS = 10000;
    localparam int ACC_ADC_TIME_US = 240;
    localparam int ACC_DAC_MAX_TIME_US = 10;
    localparam int ACC_CNT_W = 16;
    localparam int ACC_ADC_CYCLES = (ACC_ADC_TIME_US * 1000000) / ACC_CLK_PERIOD_PS;
    // A longest time rounds down.
    localparam int ACC_DAC_CYCLES = (ACC_DAC_MAX_TIME_US * 1000000) / ACC_CLK_PERIOD_PS;

    // Conversion sequencer states, one-hot.
    typedef enum logic [3:0] {
        ACC_ST_IDLE = 4'b0001,
        ACC_ST_ADC_BUSY = 4'b0010,
        ACC_ST_DAC_BUSY = 4'b0100,
        ACC_ST_ADC_LOAD = 4'b1000
    } acc_state_type;

endpackage : acc_pkg

// ==== acc_conv_timer.sv ====
// Down counter that times one conversion and flags its last cycle.
`timescale 1ns/1ps
module acc_conv_timer
    import acc_pkg::*;
#(
    parameter int CNT_W = ACC_CNT_W
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic arst_n,
    // Control.
    input wire logic load,
    input wire logic [CNT_W-1:0] load_count,
    // Status.
    output logic running,
    output logic last
);

    logic [CNT_W-1:0] count_q;

    // A new load restarts the count, which is how a second start aborts a run.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= '0;
        end else if (load) begin
            count_q <= load_count;
        end else if (count_q != '0) begin
            count_q <= count_q - 1'b1;
        end
    end

    assign running = (count_q != '0);
    assign last = (count_q == {{(CNT_W-1){1'b0}}, 1'b1}) && !load;

endmodule : acc_conv_timer

// ==== acc_top.sv ====
// Register file and conversion sequencer of the analog converter block.
`timescale 1ns/1ps
module acc_top
    import acc_pkg::*;
#(
    parameter int ADC_CONV_CYCLES = ACC_ADC_CYCLES,
    parameter int DAC_CONV_CYCLES = ACC_DAC_CYCLES
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic arst_n,
    // Core data-space access.
    input wire logic [7:0] bus_addr,
    input wire logic bus_wr_en,
    input wire logic bus_rd_en,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    // Core interrupt.
    input wire logic core_global_irq_enable,
    output logic converter_interrupt,
    // Analog front end.
    input wire logic [ACC_WORD_W-1:0] adc_code_in,
    output logic adc_sample_start,
    output logic [ACC_WORD_W-1:0] dac_code,
    output logic dac_load,
    output logic [1:0] channel_select,
    output logic [3:0] channel_input_en,
    output logic [3:0] channel_output_en,
    output logic differential_mode,
    output logic converter_busy
);

    localparam logic [ACC_CNT_W-1:0] ADC_LOAD = ACC_CNT_W'(ADC_CONV_CYCLES);
    localparam logic [ACC_CNT_W-1:0] DAC_LOAD = ACC_CNT_W'(DAC_CONV_CYCLES);

    // Register state.
    logic [ACC_WORD_W-1:0] dac_hold_q;
    logic [ACC_WORD_W-1:0] adc_result_q;
    logic done_flag_q;
    logic irq_enable_q;
    logic enable_q;
    logic direction_q;
    logic [1:0] select_q;
    logic start_q;
    acc_state_type state_q;
    acc_state_type state_d;

    // Decode and derived terms.
    logic wr_low;
    logic wr_high;
    logic wr_ctrl;
    logic done_set;
    logic flag_after_write;
    logic start_cond;
    logic timer_load;
    logic timer_last;
    logic timer_running;
    logic [ACC_CNT_W-1:0] timer_count;
    logic [ACC_WORD_W-1:0] adc_sync1_q;
    logic [ACC_WORD_W-1:0] adc_sync2_q;
    logic [ACC_WORD_W-1:0] read_word;

    assign wr_low = bus_wr_en && (bus_addr == ACC_ADDR_DATA_LOW);
    assign wr_high = bus_wr_en && (bus_addr == ACC_ADDR_DATA_HIGH);
    assign wr_ctrl = bus_wr_en && (bus_addr == ACC_ADDR_CONTROL);

    // The flag rises in the cycle after the result lands.
    assign done_set = (state_q == ACC_ST_ADC_LOAD); // R9 R17

    // Writing one keeps the flag; only a zero clears it.
    assign flag_after_write = bus_wdata[ACC_BIT_DONE] && done_flag_q; // R10

    // Start needs the write itself to leave enable set and flag clear.
    assign start_cond = wr_ctrl && bus_wdata[ACC_BIT_ENABLE] && !flag_after_write; // R11 R13

    // Holding register: every data write lands here whatever the direction.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dac_hold_q <= {ACC_RST_DATA_HIGH[ACC_HIGH_W-1:0], ACC_RST_DATA_LOW}; // R1
        end else begin
            if (wr_low) begin
                dac_hold_q[ACC_LOW_W-1:0] <= bus_wdata; // R2 R3
            end
            if (wr_high) begin
                dac_hold_q[ACC_WORD_W-1:ACC_LOW_W] <= bus_wdata[ACC_HIGH_W-1:0]; // R2 R3
            end
        end
    end

    // Control fields other than the flag; bits 6 and 5 are not stored.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_enable_q <= ACC_RST_CONTROL[ACC_BIT_IRQ_EN]; // R1
            enable_q <= ACC_RST_CONTROL[ACC_BIT_ENABLE];
            direction_q <= ACC_RST_CONTROL[ACC_BIT_DIR];
            select_q <= ACC_RST_CONTROL[ACC_BIT_SEL_HI:ACC_BIT_SEL_LO];
        end else if (wr_ctrl) begin
            irq_enable_q <= bus_wdata[ACC_BIT_IRQ_EN]; // R14 R24
            enable_q <= bus_wdata[ACC_BIT_ENABLE];
            direction_q <= bus_wdata[ACC_BIT_DIR];
            select_q <= bus_wdata[ACC_BIT_SEL_HI:ACC_BIT_SEL_LO];
        end
    end

    // Done flag: hardware set wins over a clear arriving in the same cycle.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            done_flag_q <= ACC_RST_CONTROL[ACC_BIT_DONE]; // R1
        end else if (done_set) begin
            done_flag_q <= 1'b1; // R9
        end else if (wr_ctrl) begin
            done_flag_q <= flag_after_write; // R10
        end
    end

    // Start pulse follows the start condition by exactly one edge.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            start_q <= 1'b0;
        end else begin
            start_q <= start_cond; // R12
        end
    end

    // The front-end code is asynchronous to the core clock; two stages first.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            adc_sync1_q <= '0;
            adc_sync2_q <= '0;
        end else begin
            adc_sync1_q <= adc_code_in;
            adc_sync2_q <= adc_sync1_q;
        end
    end

    // Sequencer: a start pulse always restarts, so a second start aborts.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ACC_ST_IDLE, ACC_ST_ADC_BUSY, ACC_ST_DAC_BUSY, ACC_ST_ADC_LOAD: begin
                if (start_q) begin
                    state_d = direction_q ? ACC_ST_DAC_BUSY : ACC_ST_ADC_BUSY; // R12 R16
                end else if (state_q == ACC_ST_ADC_BUSY && timer_last) begin
                    state_d = ACC_ST_ADC_LOAD; // R23
                end else if (state_q == ACC_ST_DAC_BUSY && timer_last) begin
                    state_d = ACC_ST_IDLE;
                end else if (state_q == ACC_ST_ADC_LOAD) begin
                    state_d = ACC_ST_IDLE;
                end
            end
            default: begin
                state_d = ACC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ACC_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Timer is loaded on the start pulse with the length of the chosen mode.
    assign timer_load = start_q;
    assign timer_count = direction_q ? DAC_LOAD : ADC_LOAD; // R18 R23

    acc_conv_timer #(
        .CNT_W(ACC_CNT_W)
    ) u_timer (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .load(timer_load),
        .load_count(timer_count),
        .running(timer_running),
        .last(timer_last)
    );

    // Result register takes the sampled code before the flag is raised.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            adc_result_q <= '0;
        end else if (state_q == ACC_ST_ADC_BUSY && timer_last && !start_q) begin
            adc_result_q <= adc_sync2_q; // R17 R19
        end
    end

    // Output word is handed to the generator as the conversion starts.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dac_code <= '0;
            dac_load <= 1'b0;
            adc_sample_start <= 1'b0;
        end else begin
            dac_load <= start_q && direction_q;
            adc_sample_start <= start_q && !direction_q;
            if (start_q && direction_q) begin
                dac_code <= dac_hold_q; // R22
            end
        end
    end

    // Pin directions follow the control register one cycle later.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            channel_select <= 2'h0;
            channel_input_en <= 4'h0;
            channel_output_en <= 4'h0;
            differential_mode <= 1'b0;
        end else begin
            channel_select <= select_q; // R5
            channel_input_en <= '0;
            channel_output_en <= '0;
            if (direction_q) begin
                channel_output_en[select_q] <= 1'b1; // R6
            end else begin
                channel_input_en[select_q] <= 1'b1; // R6
                if (select_q == ACC_SEL_CH_FOUR) begin
                    channel_input_en[0] <= 1'b1; // R7
                end
            end
            differential_mode <= !direction_q && (select_q == ACC_SEL_CH_FOUR); // R7
        end
    end

    // Reads show the result in input mode and the holding word otherwise.
    assign read_word = direction_q ? dac_hold_q : adc_result_q; // R4

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_rdata <= ACC_READ_ZERO;
        end else if (bus_rd_en) begin
            case (bus_addr)
                ACC_ADDR_DATA_LOW: begin
                    bus_rdata <= read_word[ACC_LOW_W-1:0]; // R2 R4
                end
                ACC_ADDR_DATA_HIGH: begin
                    bus_rdata <= {6'h00, read_word[ACC_WORD_W-1:ACC_LOW_W]}; // R2 R4
                end
                ACC_ADDR_CONTROL: begin
                    bus_rdata <= {done_flag_q, 2'h0, irq_enable_q, enable_q,
                        direction_q, select_q}; // R14 R24
                end
                default: begin
                    bus_rdata <= ACC_READ_ZERO;
                end
            endcase
        end
    end

    // Interrupt is a level gated by both enables.
    assign converter_interrupt = done_flag_q && irq_enable_q && core_global_irq_enable; // R8
    assign converter_busy = (state_q != ACC_ST_IDLE); // R23

    // Helper: length of the current input conversion, for checking only.
    logic [ACC_CNT_W-1:0] busy_len_q;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_len_q <= '0;
        end else if (state_q != ACC_ST_ADC_BUSY) begin
            busy_len_q <= '0;
        end else begin
            busy_len_q <= busy_len_q + 1'b1;
        end
    end

    sequence s_ctrl_write;
        bus_wr_en && bus_addr == ACC_ADDR_CONTROL;
    endsequence

    sequence s_adc_finish;
        state_q == ACC_ST_ADC_BUSY && timer_last && !start_q ##1 state_q == ACC_ST_ADC_LOAD;
    endsequence

    property p_start_pulse;
        @(posedge core_clk) disable iff (!arst_n)
        s_ctrl_write and (bus_wdata[ACC_BIT_ENABLE] && !bus_wdata[ACC_BIT_DONE])
            |=> start_q;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse missing"); // R11 R12

    property p_no_start_disabled;
        @(posedge core_clk) disable iff (!arst_n)
        start_q |-> enable_q && !done_flag_q;
    endproperty
    a_no_start_disabled: assert property (p_no_start_disabled) else $error("start while off"); // R13

    property p_flag_no_sw_set;
        @(posedge core_clk) disable iff (!arst_n)
        s_ctrl_write and (!done_flag_q && !done_set) |=> !done_flag_q;
    endproperty
    a_flag_no_sw_set: assert property (p_flag_no_sw_set) else $error("software set flag"); // R10

    property p_result_then_flag;
        @(posedge core_clk) disable iff (!arst_n)
        s_adc_finish |-> adc_result_q == $past(adc_sync2_q) && !done_flag_q ##1 done_flag_q;
    endproperty
    a_result_then_flag: assert property (p_result_then_flag) else $error("flag order wrong"); // R9 R17

    property p_irq_on_flag;
        @(posedge core_clk) disable iff (!arst_n)
        $rose(done_flag_q) && irq_enable_q && core_global_irq_enable |-> converter_interrupt;
    endproperty
    a_irq_on_flag: assert property (p_irq_on_flag) else $error("interrupt not raised"); // R8

    property p_dac_transfer;
        @(posedge core_clk) disable iff (!arst_n)
        start_q && direction_q |=> dac_load && dac_code == $past(dac_hold_q);
    endproperty
    a_dac_transfer: assert property (p_dac_transfer) else $error("output word not sent"); // R22

    property p_adc_length;
        @(posedge core_clk) disable iff (!arst_n)
        state_q == ACC_ST_ADC_LOAD |-> busy_len_q == ADC_LOAD;
    endproperty
    a_adc_length: assert property (p_adc_length) else $error("conversion length wrong"); // R18 R23

    property p_read_result;
        @(posedge core_clk) disable iff (!arst_n)
        bus_rd_en && bus_addr == ACC_ADDR_DATA_LOW && !direction_q
            |=> bus_rdata == $past(adc_result_q[ACC_LOW_W-1:0]);
    endproperty
    a_read_result: assert property (p_read_result) else $error("low read wrong"); // R4

    property p_write_hold;
        @(posedge core_clk) disable iff (!arst_n)
        bus_wr_en && bus_addr == ACC_ADDR_DATA_LOW
            |=> dac_hold_q[ACC_LOW_W-1:0] == $past(bus_wdata);
    endproperty
    a_write_hold: assert property (p_write_hold) else $error("holding not written"); // R3

    property p_unused_zero;
        @(posedge core_clk) disable iff (!arst_n)
        bus_rd_en && bus_addr == ACC_ADDR_CONTROL |=> bus_rdata[6:5] == 2'h0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits set"); // R24

    property p_differential;
        @(posedge core_clk) disable iff (!arst_n)
        !direction_q && select_q == ACC_SEL_CH_FOUR
            |=> differential_mode && channel_input_en == 4'h9;
    endproperty
    a_differential: assert property (p_differential) else $error("pair not set up"); // R7

    // A busy state with a stopped timer would hang the sequencer for good.
    property p_busy_timer;
        @(posedge core_clk) disable iff (!arst_n)
        state_q == ACC_ST_ADC_BUSY || state_q == ACC_ST_DAC_BUSY |-> timer_running;
    endproperty
    a_busy_timer: assert property (p_busy_timer) else $error("timer idle while busy"); // R23

endmodule : acc_top

// ==== acc_front_end.sv ====
// Behavioural model of the four analog channels and the converter front end.
`timescale 1ns/1ps
module acc_front_end
    import acc_pkg::*;
#(
    parameter logic [4*ACC_WORD_W-1:0] CH_CODES = '0,
    parameter logic [ACC_WORD_W-1:0] DIFF_CODE = '0
) (
    // Clock.
    input wire logic core_clk,
    // Channel configuration from the block.
    input wire logic [1:0] channel_select,
    input wire logic [3:0] channel_input_en,
    input wire logic differential_mode,
    // Output path from the block.
    input wire logic dac_load,
    input wire logic [ACC_WORD_W-1:0] dac_code,
    // Converter code and generator level.
    output logic [ACC_WORD_W-1:0] adc_code_in,
    output logic [ACC_WORD_W-1:0] dac_level
);
    logic [ACC_WORD_W-1:0] float_q = 10'h2aa;

    // An unselected front end floats, so it shows a changing pattern, never the last code.
    always_ff @(posedge core_clk) begin
        float_q <= ~float_q;
    end

    // Fixed codes per channel keep the expected results simple to derive.
    always_comb begin
        if (differential_mode) begin
            adc_code_in = DIFF_CODE;
        end else if (channel_input_en[channel_select]) begin
            adc_code_in = CH_CODES[channel_select*ACC_WORD_W +: ACC_WORD_W];
        end else begin
            adc_code_in = float_q;
        end
    end

    // The voltage generator takes the word only on a transfer pulse.
    always_ff @(posedge core_clk) begin
        if (dac_load) begin
            dac_level <= dac_code;
        end
    end
endmodule : acc_front_end

// ==== acc_tb.sv ====
// Self-checking testbench of the analog converter control block.
`timescale 1ns/1ps
module testbench;
    import acc_pkg::*;
    localparam int ADC_N = 20;
    localparam int DAC_N = 5;
    localparam logic [39:0] CODES = {10'h2aa, 10'h155, 10'h3ff, 10'h000};
    localparam logic [9:0] DIFF = 10'h1c3;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] bus_addr = 8'h00;
    logic bus_wr_en = 1'b0;
    logic bus_rd_en = 1'b0;
    logic [7:0] bus_wdata = 8'h00;
    logic [7:0] bus_rdata;
    logic core_global_irq_enable = 1'b0;
    logic converter_interrupt, adc_sample_start, dac_load, differential_mode, converter_busy;
    logic [9:0] adc_code_in, dac_code, dac_level, exp_code;
    logic [1:0] channel_select;
    logic [3:0] channel_input_en, channel_output_en;
    logic [7:0] rd;
    int miscompares = 0;
    int checked = 0;
    int starts = 0;
    int loads = 0;
    int busy_cycles = 0;
    int s;
    int b;

    always #5 core_clk = ~core_clk;

    acc_top #(.ADC_CONV_CYCLES(ADC_N), .DAC_CONV_CYCLES(DAC_N)) uut (
        .core_clk(core_clk), .arst_n(arst_n), .bus_addr(bus_addr), .bus_wr_en(bus_wr_en),
        .bus_rd_en(bus_rd_en), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .core_global_irq_enable(core_global_irq_enable),
        .converter_interrupt(converter_interrupt), .adc_code_in(adc_code_in),
        .adc_sample_start(adc_sample_start), .dac_code(dac_code), .dac_load(dac_load),
        .channel_select(channel_select), .channel_input_en(channel_input_en),
        .channel_output_en(channel_output_en), .differential_mode(differential_mode),
        .converter_busy(converter_busy));

    acc_front_end #(.CH_CODES(CODES), .DIFF_CODE(DIFF)) model (
        .core_clk(core_clk), .channel_select(channel_select),
        .channel_input_en(channel_input_en), .differential_mode(differential_mode),
        .dac_load(dac_load), .dac_code(dac_code), .adc_code_in(adc_code_in),
        .dac_level(dac_level));

    // Pulse and busy counters let the sequence check counts without racing the edges.
    always @(posedge core_clk) begin
        if (adc_sample_start === 1'b1) starts++;
        if (dac_load === 1'b1) loads++;
        if (converter_busy === 1'b1) busy_cycles++;
    end

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_byte

    task automatic cmp_word(input logic [9:0] got, input logic [9:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word

    // Each access leaves an idle edge so a strobe is never lowered and raised at once.
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        bus_addr = a;
        bus_wdata = d;
        bus_wr_en = 1'b1;
        @(posedge core_clk);
        #1 bus_wr_en = 1'b0;
        @(posedge core_clk);
        #1;
    endtask : bus_write

    task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
        bus_addr = a;
        bus_rd_en = 1'b1;
        @(posedge core_clk);
        #1 bus_rd_en = 1'b0;
        @(posedge core_clk);
        #1 d = bus_rdata;
    endtask : bus_read

    task automatic read_cmp(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bus_read(a, d);
        cmp_byte(d, exp);
    endtask : read_cmp

    // Polls the done flag under a bounded count, as software would.
    task automatic wait_done();
        logic [7:0] d;
        int n;
        d = 8'h00;
        for (n = 0; n < 60 && d[7] !== 1'b1; n++) bus_read(ACC_ADDR_CONTROL, d);
        if (d[7] !== 1'b1) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, d, 8'h80);
            conclude();
        end
    endtask : wait_done

    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        #1 arst_n = 1'b1;
        read_cmp(ACC_ADDR_DATA_LOW, 8'h00);
        read_cmp(ACC_ADDR_DATA_HIGH, 8'h00);
        read_cmp(ACC_ADDR_CONTROL, 8'h00);
        read_cmp(8'h9c, 8'h00);
        read_cmp(8'ha0, 8'h00);
        cmp_byte({4'h0, channel_input_en}, 8'h01);
        // Holding register loaded in input mode, then sent out on channel three.
        bus_write(ACC_ADDR_DATA_LOW, 8'ha5);
        bus_write(ACC_ADDR_DATA_HIGH, 8'h03);
        read_cmp(ACC_ADDR_DATA_LOW, 8'h00);
        s = loads;
        b = busy_cycles;
        bus_write(ACC_ADDR_CONTROL, 8'h0e);
        repeat (DAC_N + 4) @(posedge core_clk);
        #1 cmp_byte(8'(loads - s), 8'h01);
        cmp_byte(8'(busy_cycles - b), 8'(DAC_N));
        cmp_word(dac_code, 10'h3a5);
        cmp_word(dac_level, 10'h3a5);
        cmp_byte({channel_output_en, channel_input_en}, 8'h40);
        read_cmp(ACC_ADDR_DATA_LOW, 8'ha5);
        read_cmp(ACC_ADDR_DATA_HIGH, 8'h03);
        read_cmp(ACC_ADDR_CONTROL, 8'h0e);
        // Input conversions on every channel; the first differential result is discarded.
        for (int i = 0; i < 5; i++) begin
            automatic logic [1:0] sel = (i > 3) ? 2'h3 : 2'(i);
            exp_code = (sel == ACC_SEL_CH_FOUR) ? DIFF : CODES[sel*10 +: 10];
            b = busy_cycles;
            bus_write(ACC_ADDR_CONTROL, 8'h08 | 8'(sel));
            wait_done();
            read_cmp(ACC_ADDR_CONTROL, 8'h88 | 8'(sel));
            // The load cycle after the count keeps the block busy one cycle longer.
            cmp_byte(8'(busy_cycles - b), 8'(ADC_N + 1));
            cmp_byte({4'h0, channel_input_en}, (sel == 2'h3) ? 8'h09 : 8'h01 << sel);
            cmp_byte({6'h00, channel_select}, {6'h00, sel});
            cmp_byte({7'h00, differential_mode}, {7'h00, sel == 2'h3});
            if (i != 3) begin
                read_cmp(ACC_ADDR_DATA_LOW, exp_code[7:0]);
                read_cmp(ACC_ADDR_DATA_HIGH, {6'h00, exp_code[9:8]});
            end
        end
        cmp_byte(8'(starts), 8'h05);
        // Writing one to the flag keeps it and starts nothing.
        bus_write(ACC_ADDR_CONTROL, 8'h9b);
        cmp_byte({7'h00, converter_interrupt}, 8'h00);
        core_global_irq_enable = 1'b1;
        @(posedge core_clk);
        #1 cmp_byte({7'h00, converter_interrupt}, 8'h01);
        read_cmp(ACC_ADDR_CONTROL, 8'h9b);
        cmp_byte(8'(starts), 8'h05);
        // Clearing the flag with the enable off starts nothing.
        bus_write(ACC_ADDR_CONTROL, 8'h13);
        cmp_byte({7'h00, converter_interrupt}, 8'h00);
        read_cmp(ACC_ADDR_CONTROL, 8'h13);
        // A conversion finishing with both enables set raises the interrupt.
        bus_write(ACC_ADDR_CONTROL, 8'h18);
        wait_done();
        cmp_byte({7'h00, converter_interrupt}, 8'h01);
        bus_write(ACC_ADDR_CONTROL, 8'h60);
        cmp_byte({7'h00, converter_interrupt}, 8'h00);
        read_cmp(ACC_ADDR_CONTROL, 8'h00);
        // Data writes in input mode still reach the holding register.
        s = loads;
        bus_write(ACC_ADDR_DATA_LOW, 8'h3c);
        bus_write(ACC_ADDR_DATA_HIGH, 8'h01);
        bus_write(ACC_ADDR_CONTROL, 8'h04);
        repeat (DAC_N + 4) @(posedge core_clk);
        #1 cmp_byte(8'(loads - s), 8'h00);
        read_cmp(ACC_ADDR_DATA_LOW, 8'h3c);
        read_cmp(ACC_ADDR_DATA_HIGH, 8'h01);
        cmp_byte(8'(starts), 8'h06);
        // A reset while idle must bring every register back to zero.
        arst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 arst_n = 1'b1;
        read_cmp(ACC_ADDR_CONTROL, 8'h00);
        read_cmp(ACC_ADDR_DATA_LOW, 8'h00);
        read_cmp(ACC_ADDR_DATA_HIGH, 8'h00);
        conclude();
    end
endmodule : testbench
